/* common/sft_pkg.sv */
// constants, field layouts and register map of the scan frame transmitter
// assumes a 125 MHz system clock and an Avalon-MM host for configuration
// Operation
// - one-way output only; frame layout fixed, no receive path.
// - after self-test done, frames go out continuously without any request.
// - each 40 ms rotation splits into measuring arc and transfer arc.
// - bit rate 57.6 kbit/s default, 115.2 kbit/s selectable; receiver matches.
// - up to 529 distance samples of 16 bits per rotation.
// - buffer drained before refill; scans arriving while busy are dropped.
// - sending starts past the stop segment, ends back at start segment.
// - all segments suppressed extends the transfer window to 35 ms.
// - step size keeps one sample per group of beams, 0.36 degree units.
// - 687.5 kbit/s rate supported for full scans at 25 per second.
// - above 115200 baud the configuration dialogue is not served.
// - field order start, op, options, scan, step, angles, data, check, end.
// - option byte 1 always sent with state and following options.
// - measurement frames carry option bytes 2 and 3.
// - scan counter steps by one per scan, sent in eight bytes.
// - an angle field grows to three bytes when stuffing hits it.
// - check byte is XOR of all characters sent before it.
// - after two zero bytes a 0xff stuffing byte is inserted.
// - distance samples go high byte first; stuffing spans samples.
// - every frame opens with two zero bytes.
// - op codes 0x14 alive, 0x23 measurement, 0x53 error, 0x54 warning.
// - option 1 low bits give options present, next three the state.
// - scan number most significant first, 0xfe after each byte.
// - option 2 bit layout of field occupancy and state flags.
package sft_pkg;
   localparam int CLK_HZ = 125_000_000;
   localparam int BAUD_LO = 57_600;
   localparam int BAUD_HI = 115_200;
   localparam int BAUD_FAST = 687_500;
   localparam logic [11:0] DIV_LO = 12'(CLK_HZ / BAUD_LO);
   localparam logic [11:0] DIV_HI = 12'(CLK_HZ / BAUD_HI);
   localparam logic [11:0] DIV_FAST = 12'(CLK_HZ / BAUD_FAST);
   localparam int XFER_EXT_MS = 35;
   localparam int XFER_EXT_CYC_DEF = XFER_EXT_MS * (CLK_HZ / 1000);
   localparam int ROTATION_MS = 40;
   localparam int MAX_SAMPLES = 529;
   localparam logic [9:0] SAMPLES_LAST = 10'(MAX_SAMPLES - 1);
   localparam logic [3:0] CHAR_BITS = 4'ha;
   localparam logic [1:0] RATE_LO = 2'h0;
   localparam logic [1:0] RATE_HI = 2'h1;
   localparam logic [1:0] RATE_FAST = 2'h2;
   localparam logic [7:0] OP_ALIVE = 8'h14;
   localparam logic [7:0] OP_MEAS = 8'h23;
   localparam logic [7:0] OP_ERROR = 8'h53;
   localparam logic [7:0] OP_WARN = 8'h54;
   localparam logic [1:0] OPT_ONLY1 = 2'h1;
   localparam logic [1:0] OPT_ALL = 2'h3;
   localparam logic [2:0] ST_INIT = 3'h1;
   localparam logic [2:0] ST_NORMAL = 3'h2;
   localparam logic [2:0] ST_FAULT = 3'h4;
   localparam logic [7:0] STUFF_BYTE = 8'hff;
   localparam logic [7:0] SCAN_FILL = 8'hfe;
   localparam logic [23:0] END_PATTERN = 24'h030201;
   // register byte offsets
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_STEP = 5'h04;
   localparam logic [4:0] REG_ANGLE = 5'h08;
   localparam logic [4:0] REG_PAIR = 5'h0c;
   localparam logic [4:0] REG_STATUS = 5'h10;
   localparam logic [4:0] REG_SCAN = 5'h14;
   // reset values
   localparam logic [1:0] RST_RATE = RATE_LO;
   localparam logic [7:0] RST_STEP = 8'h01;
   localparam logic [9:0] RST_START = 10'h001;
   localparam logic [9:0] RST_STOP = 10'h211;
   localparam logic [2:0] RST_PAIR = 3'h1;
   // field positions
   localparam int CTRL_SUP_BIT = 2;
   localparam int ANG_STOP_LSB = 16;
   localparam int PAIR2_LSB = 3;
   typedef enum logic [3:0] {
      S_IDLE, S_START, S_OP, S_OPT1, S_OPT2, S_OPT3, S_SCAN, S_STEP,
      S_ANG, S_DIST, S_CHK, S_END
   } sft_state_t;
endpackage : sft_pkg

/* hw/sft_top.sv */
// scan frame transmitter: buffers one scan and sends it as a stuffed frame
// scan inputs and beam position come from logic on clk_sys; txd is 8N1
//
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
module sft_top
   import sft_pkg::*;
#(
   parameter int unsigned XFER_EXT_CYC = XFER_EXT_CYC_DEF
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic selftest_done,
   input wire logic scan_begin,
   input wire logic scan_end,
   input wire logic sample_valid,
   input wire logic [15:0] sample_dist,
   input wire logic [9:0] beam_segment,
   input wire logic fault,
   input wire logic warning,
   input wire logic near1_occ,
   input wire logic far1_occ,
   input wire logic near2_occ,
   input wire logic far2_occ,
   input wire logic restart_dis,
   input wire logic outputs_on,
   output logic txd,
   output logic dialogue_ok,
   output logic scan_dropped
);

   typedef struct packed {
      sft_state_t st;
      logic [2:0] idx;
      logic prev_zero;
      logic stuff_pend;
      logic [7:0] xsum;
      logic meas;
      logic [7:0] op;
      logic [11:0] baud_cnt;
      logic [3:0] bit_cnt;
      logic [9:0] shreg;
      logic cap_on;
      logic [9:0] beam;
      logic [7:0] grp_cnt;
      logic [15:0] grp_min;
      logic [9:0] wr_idx;
      logic buf_full;
      logic [9:0] buf_len;
      logic [31:0] buf_scan;
      logic [9:0] rd_idx;
      logic [31:0] scan_num;
      logic [22:0] ext_cnt;
      logic dropped;
      logic [1:0] rate;
      logic all_sup;
      logic [7:0] step;
      logic [9:0] ang_start;
      logic [9:0] ang_stop;
      logic [2:0] pair1;
      logic [2:0] pair2;
      logic ack;
      logic [31:0] rdata;
   } sft_regs_t;

   sft_regs_t s_r;
   sft_regs_t s_nxt;

   logic [15:0] buf_mem [MAX_SAMPLES];
   logic [15:0] mem_q_r;
   logic mem_we;
   logic [9:0] mem_wa;
   logic [15:0] mem_wd;

   function automatic logic [11:0] sft_baud_div(input logic [1:0] rate);
      unique case (rate)
         RATE_HI: sft_baud_div = DIV_HI;
         RATE_FAST: sft_baud_div = DIV_FAST;
         default: sft_baud_div = DIV_LO;
      endcase
   endfunction : sft_baud_div

   logic window;
   logic in_arc;
   logic [7:0] step_eff;
   logic [9:0] beam_n;
   logic [15:0] min_n;
   logic take;
   logic [7:0] tx_byte;
   logic stuffable;
   logic sum_byte;

   always_comb begin
      // transfer outside the configured measuring arc, and inside it while all_sup extends the window
      in_arc = (beam_segment >= s_r.ang_start)
         && (beam_segment <= s_r.ang_stop);
      // suppressed segments keep the window open for 35 ms
      window = !in_arc || (s_r.all_sup
         && (32'(s_r.ext_cnt) < XFER_EXT_CYC));
      step_eff = (s_r.step == 8'h00) ? 8'h01 : s_r.step;
      beam_n = s_r.beam + 10'h001;
      min_n = (sample_dist < s_r.grp_min) ? sample_dist : s_r.grp_min;
   end

   always_comb begin
      s_nxt = s_r;
      mem_we = 1'b0;
      mem_wa = s_r.wr_idx;
      mem_wd = min_n;
      take = 1'b0;
      tx_byte = 8'h00;
      stuffable = 1'b1;
      sum_byte = 1'b1;
      s_nxt.dropped = 1'b0;

      // register bus: one wait cycle; writes land on the completing edge
      s_nxt.ack = (avs_read || avs_write) && !s_r.ack;
      if ((avs_read && !s_r.ack) || (avs_write && s_r.ack)) begin
         s_nxt.rdata = 32'h0000_0000;
         if (avs_write) begin
            unique case (avs_address)
               REG_CTRL: begin
                  // rate select, default after reset is 57.6k
                  s_nxt.rate = avs_writedata[1:0];
                  s_nxt.all_sup = avs_writedata[CTRL_SUP_BIT];
               end
               REG_STEP: s_nxt.step = avs_writedata[7:0];
               REG_ANGLE: begin
                  s_nxt.ang_start = avs_writedata[9:0];
                  s_nxt.ang_stop = avs_writedata[ANG_STOP_LSB +: 10];
               end
               REG_PAIR: begin
                  s_nxt.pair1 = avs_writedata[2:0];
                  s_nxt.pair2 = avs_writedata[PAIR2_LSB +: 3];
               end
               default: ;
            endcase
         end else begin
            unique case (avs_address)
               REG_CTRL: s_nxt.rdata = {29'h0, s_r.all_sup, s_r.rate};
               REG_STEP: s_nxt.rdata = {24'h0, s_r.step};
               REG_ANGLE: s_nxt.rdata = {6'h0, s_r.ang_stop, 6'h0,
                  s_r.ang_start};
               REG_PAIR: s_nxt.rdata = {26'h0, s_r.pair2, s_r.pair1};
               REG_STATUS: s_nxt.rdata = {6'h0, s_r.buf_len, 9'h0,
                  s_r.cap_on, s_r.buf_full, (s_r.st != S_IDLE), s_r.st};
               REG_SCAN: s_nxt.rdata = s_r.scan_num;
               default: ;
            endcase
         end
      end

      // extension timer restarts as the beam reaches the stop segment
      if (beam_segment == s_r.ang_stop) begin
         s_nxt.ext_cnt = 23'h0;
      end else if (s_r.ext_cnt != 23'h7fffff) begin
         s_nxt.ext_cnt = s_r.ext_cnt + 23'h1;
      end

      // capture side
      if (scan_begin) begin
         // a full buffer refuses the new scan
         if (s_r.buf_full) begin
            s_nxt.dropped = 1'b1;
         end else begin
            s_nxt.cap_on = 1'b1;
            s_nxt.wr_idx = 10'h0;
            s_nxt.beam = 10'h0;
            s_nxt.grp_cnt = 8'h0;
            s_nxt.grp_min = 16'hffff;
         end
      end else if (sample_valid && s_r.cap_on) begin
         s_nxt.beam = beam_n;
         // at most 529 samples land in the buffer
         if (beam_n >= s_r.ang_start && beam_n <= s_r.ang_stop
               && s_r.wr_idx <= SAMPLES_LAST) begin
            s_nxt.grp_min = min_n;
            s_nxt.grp_cnt = s_r.grp_cnt + 8'h01;
            // one sample, the group minimum, per step
            if (s_nxt.grp_cnt == step_eff || beam_n == s_r.ang_stop) begin
               mem_we = 1'b1;
               s_nxt.wr_idx = s_r.wr_idx + 10'h001;
               s_nxt.grp_cnt = 8'h0;
               s_nxt.grp_min = 16'hffff;
            end
         end
      end
      if (scan_end) begin
         // every scan advances the counter by one
         s_nxt.scan_num = s_r.scan_num + 32'h1;
         if (s_r.cap_on) begin
            s_nxt.cap_on = 1'b0;
            s_nxt.buf_full = 1'b1;
            s_nxt.buf_len = s_nxt.wr_idx;
            s_nxt.buf_scan = s_r.scan_num;
         end
      end

      // 8N1 shifter, start bit low, lsb first
      if (s_r.bit_cnt != 4'h0) begin
         if (s_r.baud_cnt == 12'h0) begin
            s_nxt.baud_cnt = sft_baud_div(s_r.rate) - 12'h1;
            s_nxt.shreg = {1'b1, s_r.shreg[9:1]};
            s_nxt.bit_cnt = s_r.bit_cnt - 4'h1;
         end else begin
            s_nxt.baud_cnt = s_r.baud_cnt - 12'h1;
         end
      end

      // frame builder
      unique case (s_r.st)
         S_IDLE: begin
            // frames follow each other once self-test is done
            if (selftest_done && window && s_r.bit_cnt == 4'h0) begin
               s_nxt.st = S_START;
               s_nxt.idx = 3'h0;
               s_nxt.xsum = 8'h00;
               s_nxt.prev_zero = 1'b0;
               s_nxt.stuff_pend = 1'b0;
               s_nxt.rd_idx = 10'h0;
               s_nxt.meas = s_r.buf_full && !fault && !warning;
               // frame type chosen once per frame
               s_nxt.op = fault ? OP_ERROR : warning ? OP_WARN
                  : s_r.buf_full ? OP_MEAS : OP_ALIVE;
            end
         end
         default: begin
            // a frame in progress waits while the beam measures
            take = (s_r.bit_cnt == 4'h0) && window;
         end
      endcase

      if (take) begin
         if (s_r.stuff_pend) begin
            // stuffing byte after a zero pair
            tx_byte = STUFF_BYTE;
            s_nxt.stuff_pend = 1'b0;
         end else begin
            unique case (s_r.st)
               S_START: begin
                  // two zero bytes open the frame
                  stuffable = 1'b0;
                  s_nxt.idx = s_r.idx + 3'h1;
                  if (s_r.idx == 3'h1) begin
                     s_nxt.st = S_OP;
                  end
               end
               S_OP: begin
                  tx_byte = s_r.op;
                  s_nxt.st = S_OPT1;
               end
               S_OPT1: begin
                  tx_byte = {3'h0, fault ? ST_FAULT
                     : selftest_done ? ST_NORMAL : ST_INIT,
                     s_r.meas ? OPT_ALL : OPT_ONLY1};
                  s_nxt.st = s_r.meas ? S_OPT2 : S_SCAN;
                  s_nxt.idx = 3'h0;
               end
               S_OPT2: begin
                  tx_byte = {1'b1, far2_occ, near2_occ, restart_dis,
                     fault, warning, far1_occ, near1_occ};
                  s_nxt.st = S_OPT3;
               end
               S_OPT3: begin
                  tx_byte = {1'b1, outputs_on, s_r.pair2, s_r.pair1};
                  s_nxt.st = S_SCAN;
               end
               S_SCAN: begin
                  // msb first, fill byte after each byte
                  if (s_r.idx[0]) begin
                     tx_byte = SCAN_FILL;
                  end else begin
                     tx_byte = 8'((s_r.meas ? s_r.buf_scan : s_r.scan_num)
                        >> {~s_r.idx[2:1], 3'h0});
                  end
                  s_nxt.idx = s_r.idx + 3'h1;
                  if (s_r.idx == 3'h7) begin
                     s_nxt.st = S_STEP;
                  end
               end
               S_STEP: begin
                  tx_byte = step_eff;
                  s_nxt.st = S_ANG;
                  s_nxt.idx = 3'h0;
               end
               S_ANG: begin
                  // zero pairs here stuff like any other byte
                  unique case (s_r.idx[1:0])
                     2'h0: tx_byte = {6'h0, s_r.ang_start[9:8]};
                     2'h1: tx_byte = s_r.ang_start[7:0];
                     2'h2: tx_byte = {6'h0, s_r.ang_stop[9:8]};
                     2'h3: tx_byte = s_r.ang_stop[7:0];
                  endcase
                  s_nxt.idx = s_r.idx + 3'h1;
                  if (s_r.idx == 3'h3) begin
                     s_nxt.idx = 3'h0;
                     s_nxt.st = (s_r.meas && s_r.buf_len != 10'h0)
                        ? S_DIST : S_CHK;
                  end
               end
               S_DIST: begin
                  tx_byte = s_r.idx[0] ? mem_q_r[7:0] : mem_q_r[15:8];
                  s_nxt.idx = {2'h0, ~s_r.idx[0]};
                  if (s_r.idx[0]) begin
                     s_nxt.rd_idx = s_r.rd_idx + 10'h001;
                     if (s_nxt.rd_idx == s_r.buf_len) begin
                        s_nxt.st = S_CHK;
                        // buffer free only after the last sample
                        s_nxt.buf_full = 1'b0;
                     end
                  end
               end
               S_CHK: begin
                  // xor of every character before it
                  tx_byte = s_r.xsum;
                  sum_byte = 1'b0;
                  s_nxt.st = S_END;
                  s_nxt.idx = 3'h0;
               end
               S_END: begin
                  tx_byte = 8'(END_PATTERN >> {s_r.idx[1:0], 3'h0});
                  stuffable = 1'b0;
                  sum_byte = 1'b0;
                  s_nxt.idx = s_r.idx + 3'h1;
                  if (s_r.idx == 3'h2) begin
                     s_nxt.st = S_IDLE;
                  end
               end
               default: s_nxt.st = S_IDLE;
            endcase
            // second zero in a row schedules a stuffing byte
            s_nxt.stuff_pend = stuffable && s_r.prev_zero
               && tx_byte == 8'h00;
         end
         s_nxt.prev_zero = stuffable && !s_nxt.stuff_pend
            && tx_byte == 8'h00 && !s_r.stuff_pend;
         // stuffing bytes count as characters too
         if (sum_byte) begin
            s_nxt.xsum = s_r.xsum ^ tx_byte;
         end
         s_nxt.shreg = {1'b1, tx_byte, 1'b0};
         s_nxt.bit_cnt = CHAR_BITS;
         s_nxt.baud_cnt = sft_baud_div(s_r.rate) - 12'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         s_r <= '0;
         s_r.st <= S_IDLE;
         s_r.shreg <= 10'h3ff;
         s_r.grp_min <= 16'hffff;
         s_r.rate <= RST_RATE;
         s_r.step <= RST_STEP;
         s_r.ang_start <= RST_START;
         s_r.ang_stop <= RST_STOP;
         s_r.pair1 <= RST_PAIR;
         s_r.pair2 <= RST_PAIR;
      end else begin
         s_r <= s_nxt;
      end
   end

   // block ram style storage; read one cycle behind the index
   always_ff @(posedge clk_sys) begin
      if (mem_we) begin
         buf_mem[mem_wa] <= mem_wd;
      end
      mem_q_r <= buf_mem[s_r.rd_idx];
   end

   assign txd = s_r.shreg[0];
   // dialogue only at rates up to 115200
   assign dialogue_ok = (s_r.rate != RATE_FAST);
   assign scan_dropped = s_r.dropped;
   assign avs_readdata = s_r.rdata;
   assign avs_waitrequest = (avs_read || avs_write) && !s_r.ack;

endmodule : sft_top

/* verification/sft_chk.sv */
// port checker for the scan frame transmitter
// assumes it is bound into sft_top, all on clk_sys
`timescale 1ns/1ns
module sft_chk
   import sft_pkg::*;
#(
   parameter int unsigned XFER_EXT_CYC = XFER_EXT_CYC_DEF
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic selftest_done,
   input wire logic scan_begin,
   input wire logic txd,
   input wire logic dialogue_ok,
   input wire logic scan_dropped
);
   logic [1:0] rate_r;
   logic [15:0] low_r;
   int div;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   // rate can be rewritten at any time; the shadow copy takes each write on the same edge as the register
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         rate_r <= RST_RATE;
         low_r <= 16'h0000;
      end else begin
         if (avs_write && !avs_waitrequest && avs_address == REG_CTRL)
            rate_r <= avs_writedata[1:0];
         low_r <= txd ? 16'h0000 : low_r + 16'h0001;
      end
   end
   always_comb begin
      div = (rate_r == RATE_HI) ? int'(DIV_HI) :
         (rate_r == RATE_FAST) ? int'(DIV_FAST) : int'(DIV_LO);
   end
   a_quiet_before_test: assert property (!selftest_done |-> txd)
      else $error("txd active before self-test done");
   a_char_timing: assert property ($rose(txd) |->
      (low_r % div == 0) && (low_r <= 9 * div))
      else $error("low run on txd not whole bits of the set rate");
   a_wait_first: assert property (
      $rose(avs_read || avs_write) |-> avs_waitrequest)
      else $error("no wait state in first request cycle");
   a_wait_once: assert property (
      ((avs_read || avs_write) && avs_waitrequest) |=>
      (!avs_waitrequest || !(avs_read || avs_write)))
      else $error("more than one wait state");
   a_rate_dialogue: assert property (
      (avs_write && !avs_waitrequest && avs_address == REG_CTRL) |=>
      (dialogue_ok == ($past(avs_writedata[1:0]) != RATE_FAST)))
      else $error("dialogue flag does not follow rate");
   a_unmapped_zero: assert property (
      (avs_read && !avs_waitrequest && avs_address > REG_SCAN) |->
      (avs_readdata == 32'h0))
      else $error("unmapped read not zero");
   a_rd_hold: assert property (
      (!avs_read && !avs_write) |=> $stable(avs_readdata))
      else $error("read data moved while bus idle");
   a_drop_cause: assert property (scan_dropped |-> $past(scan_begin))
      else $error("drop pulse without scan start");
   a_drop_single: assert property (scan_dropped |=> !scan_dropped)
      else $error("drop pulse longer than one cycle");
endmodule : sft_chk
bind sft_top sft_chk #(.XFER_EXT_CYC(XFER_EXT_CYC)) chk (
   .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .selftest_done(selftest_done),
   .scan_begin(scan_begin), .txd(txd), .dialogue_ok(dialogue_ok),
   .scan_dropped(scan_dropped));

/* verification/sft_rx_model.sv */
// serial receiver at the far end of txd, as a controller or PC would be
// assumes 8N1 characters at a bit period of DIV clk_sys cycles
`timescale 1ns/1ns
module sft_rx_model #(
   // receiver runs at the configured rate
   parameter int DIV = 181
) (
   input wire logic clk_sys,
   input wire logic txd,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_bad
);
   logic [7:0] b;
   initial begin
      rx_valid = 1'b0;
      rx_bad = 1'b0;
      rx_data = 8'h00;
      forever begin
         @(posedge clk_sys);
         if (txd === 1'b0) begin
            // sample mid-bit so edge jitter of a cycle does no harm
            repeat (DIV / 2) @(posedge clk_sys);
            for (int i = 0; i < 8; i++) begin
               repeat (DIV) @(posedge clk_sys);
               b[i] = txd;
            end
            repeat (DIV) @(posedge clk_sys);
            rx_bad <= (txd !== 1'b1);
            rx_data <= b;
            rx_valid <= 1'b1;
            @(posedge clk_sys);
            rx_valid <= 1'b0;
            rx_bad <= 1'b0;
         end
      end
   end
endmodule : sft_rx_model

/* verification/sft_top_bench.sv */
// self-checking bench: registers, scan capture, frame contents on txd
// assumes sft_top, the receiver model and a 125 MHz clock
`timescale 1ns/1ns
module sft_top_bench;
   import sft_pkg::*;
   logic clk_sys = 0, reset_n = 0, avs_read = 0, avs_write = 0;
   logic [4:0] avs_address = 0;
   logic [31:0] avs_writedata = 0, avs_readdata, seed = 32'd10019;
   logic avs_waitrequest, txd, dialogue_ok, scan_dropped;
   logic selftest_done = 0, scan_begin = 0, scan_end = 0;
   logic sample_valid = 0, fault = 0, warning = 0, near1_occ = 0;
   logic far1_occ = 0, near2_occ = 0, far2_occ = 0, restart_dis = 0;
   logic outputs_on = 0, rx_valid, rx_bad;
   logic [15:0] sample_dist = 0;
   logic [9:0] beam_segment = 10'h001;
   logic [7:0] rx_data, got[$];
   int err_total = 0, n_tests = 0, chk, zr, exq[$];
   always #4 clk_sys = ~clk_sys;
   sft_top #(.XFER_EXT_CYC(2000)) uut (.clk_sys(clk_sys),
      .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .selftest_done(selftest_done), .scan_begin(scan_begin),
      .scan_end(scan_end), .sample_valid(sample_valid),
      .sample_dist(sample_dist), .beam_segment(beam_segment),
      .fault(fault), .warning(warning), .near1_occ(near1_occ),
      .far1_occ(far1_occ), .near2_occ(near2_occ), .far2_occ(far2_occ),
      .restart_dis(restart_dis), .outputs_on(outputs_on), .txd(txd),
      .dialogue_ok(dialogue_ok), .scan_dropped(scan_dropped));
   sft_rx_model #(.DIV(int'(DIV_FAST))) rx (.clk_sys(clk_sys), .txd(txd),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_bad(rx_bad));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   task automatic cmp(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : cmp
   task automatic tally_and_finish;
      if (err_total == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish
   // request stands until waitrequest is sampled low at a rising edge
   task automatic bus(input logic wr, input logic [4:0] a,
      input logic [31:0] wd, output logic [31:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= wd;
      avs_read <= !wr;
      avs_write <= wr;
      do begin
         @(posedge clk_sys);
         d = avs_readdata;
      end while (avs_waitrequest !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic add(input int b);
      exq.push_back(b);
      chk ^= b;
      zr = (b == 0) ? zr + 1 : 0;
      if (zr == 2) begin
         exq.push_back(255);
         chk ^= 255;
         zr = 0;
      end
   endtask : add
   task automatic pulse_sample(input logic [15:0] dv);
      @(posedge clk_sys);
      sample_valid <= 1'b1;
      sample_dist <= dv;
      @(posedge clk_sys);
      sample_valid <= 1'b0;
   endtask : pulse_sample
   task automatic wait_bytes(input int n);
      while (got.size() < n) @(posedge clk_sys);
   endtask : wait_bytes
   always @(posedge clk_sys) begin
      if (rx_valid === 1'b1) begin
         got.push_back(rx_data);
         cmp("stop bit", 0, {31'h0, rx_bad});
      end
   end
   initial begin
      repeat (95000) @(posedge clk_sys);
      err_total++;
      tally_and_finish;
   end
   initial begin
      logic [31:0] d, rv[7];
      logic [7:0] o2, o3;
      int fr[21], f2[12], n;
      rv = '{32'h0, 32'h1, 32'h0211_0001, 32'h9, 32'h0, 32'h0, 32'h0};
      repeat (10) @(posedge clk_sys);
      reset_n <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         bus(1'b0, 5'(i * 4), 32'h0, d);
         cmp("reg reset", rv[i], d);
      end
      bus(1'b1, REG_CTRL, {30'h0, RATE_HI}, d);
      @(negedge clk_sys);
      cmp("dialogue", 1, {31'h0, dialogue_ok});
      bus(1'b1, REG_CTRL, {30'h0, RATE_FAST}, d);
      @(negedge clk_sys);
      cmp("dialogue", 0, {31'h0, dialogue_ok});
      bus(1'b1, REG_ANGLE, 32'h0002_0001, d);
      seed = xs(seed);
      bus(1'b1, REG_PAIR, {26'h0, seed[5:0]}, d);
      {near1_occ, far1_occ, near2_occ, far2_occ} <= seed[11:8];
      {restart_dis, outputs_on} <= seed[13:12];
      @(posedge clk_sys);
      scan_begin <= 1'b1;
      @(posedge clk_sys);
      scan_begin <= 1'b0;
      pulse_sample(16'h0100);
      pulse_sample(16'h00fa);
      @(posedge clk_sys);
      scan_end <= 1'b1;
      @(posedge clk_sys);
      scan_end <= 1'b0;
      bus(1'b0, REG_STATUS, 32'h0, d);
      cmp("buffer full", 1, {31'h0, d[5]});
      @(posedge clk_sys);
      scan_begin <= 1'b1;
      @(posedge clk_sys);
      scan_begin <= 1'b0;
      @(negedge clk_sys);
      cmp("scan dropped", 1, {31'h0, scan_dropped});
      bus(1'b0, REG_SCAN, 32'h0, d);
      cmp("scan count", 1, d);
      cmp("early bytes", 0, got.size());
      selftest_done <= 1'b1;
      beam_segment <= 10'h064;
      o2 = {1'b1, far2_occ, near2_occ, restart_dis, 2'b00, far1_occ,
         near1_occ};
      o3 = {1'b1, outputs_on, seed[5:0]};
      fr = '{OP_MEAS, {3'h0, ST_NORMAL, OPT_ALL}, o2, o3, 0, 254, 0, 254,
         0, 254, 0, 254, 1, 0, 1, 0, 2, 1, 0, 0, 250};
      exq = '{0, 0};
      chk = 0;
      zr = 0;
      foreach (fr[i]) add(fr[i]);
      n = chk;
      add(n);
      exq = {exq, 1, 2, 3};
      n = exq.size();
      wait_bytes(n - 2);
      fault <= 1'b1;
      f2 = '{0, 0, OP_ERROR, {3'h0, ST_FAULT, OPT_ONLY1}, 0, 254, 0, 254,
         0, 254, 1, 254};
      wait_bytes(n + 12);
      foreach (exq[i])
         cmp("meas frame", exq[i], {24'h0, got[i]});
      foreach (f2[i])
         cmp("error frame", f2[i], {24'h0, got[n + i]});
      bus(1'b0, REG_STATUS, 32'h0, d);
      cmp("buffer drained", 0, {31'h0, d[5]});
      tally_and_finish;
   end
endmodule : sft_top_bench
